// ==== fhc_frontplane_ctl.sv ====
/*
   Frontplane control of a 16-bit parallel adapter: interrupt request,
   24-bit transfer counter, two handshake state machines, strobe stretcher
   and peripheral flag filter, plus an 8-bit software register port.
   Assumes FIFO status, attention, end and flag inputs are asynchronous,
   and the controller clear input comes from logic on ref_clk.
*/
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Interrupt raised once; rearmed only after all active sources have cleared.
// - Attention input raises interrupt directly; a separate flag records it.
// - Peripheral-end and zero-count sources each gated by their own mask bit.
// - Peripheral-end and attention inputs synchronised before interrupt or handshake use.
// - An extra output enables the frontplane data line drivers.
// - Transfer counter is three cascaded 8-bit stages linked by carry.
// - Counter counts up, clears on reset; top carry marks terminal count.
// - All FIFO control inputs except mode bits are synchronised.
// - Strobe combines two never-coincident active-low terms, one per machine.
// - Controller clear idles both machines, strobes and driver enable high, shift and request outputs low.
// - Burst while nine words room or data; below, stop or go single.
// - Strobe assertion delayable 0, 50, 100 or 150 ns via shift taps.
// - On strobe release all stretch stages go high next step.
// - Flag filter offers 0, 50, 100, 150 ns; zero just registers.
// - Differing input sets first stage, then one more per step; output follows the step after the selected stage.
// - Input equal to output clears all filter stages, restarting qualification.
// - Hard reset clears every software-writable control register.
// - One control bit selects both direction and handshake-end options.
module fhc_frontplane_ctl
   import fhc_pkg::*;
(
   input  wire logic                      ref_clk,
   input  wire logic                      rst_n,
   input  wire logic                      ctrlClr_n,
   input  wire logic [fhc_pkg::ADDR_W-1:0] regAddr,
   input  wire logic [fhc_pkg::DATA_W-1:0] regWrData,
   input  wire logic                      regWrStb,
   input  wire logic                      regRdStb,
   output logic      [fhc_pkg::DATA_W-1:0] regRdData,
   input  wire logic                      attentionInput,
   input  wire logic                      peripheralEndInput,
   input  wire logic                      peripheralFlagInput,
   input  wire logic                      fifoHalfFull,
   input  wire logic                      fifoNearLimit,
   input  wire logic                      fifoInputReady,
   input  wire logic                      fifoOutputReady,
   output logic                           irq,
   output logic                           dataDrvEn_n,
   output logic                           outboundStrobeTerm_n,
   output logic                           inboundStrobeTerm_n,
   output logic                           peripheralStrobe_n,
   output logic                           fifoShiftOut,
   output logic                           fifoShiftIn,
   output logic                           burstRequest,
   output logic                           singleRequest,
   output logic                           peripheralDirectionOption,
   output logic                           handshakeEndOption,
   output logic                           termCount
);
   import fhc_pkg::*;

   // ------------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------------
   logic rstMeta_r;
   logic rstSync_r;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rstMeta_r <= 1'b0;
         rstSync_r <= 1'b0;
      end
      else
      begin
         rstMeta_r <= 1'b1;
         rstSync_r <= rstMeta_r;
      end
   end

   // ------------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------------
   // Order: attention, end, flag, half full, near limit, in ready, out ready
   logic [6:0] asyncIn;
   logic [6:0] syncMeta_r;
   logic [6:0] sync_r;

   assign asyncIn = {fifoOutputReady, fifoInputReady, fifoNearLimit, fifoHalfFull,
                     peripheralFlagInput, peripheralEndInput, attentionInput};

   always_ff @(posedge ref_clk or negedge rstSync_r)
   begin
      if (!rstSync_r)
      begin
         syncMeta_r <= 7'h00;
         sync_r     <= 7'h00;
      end
      else
      begin
         syncMeta_r <= asyncIn;
         sync_r     <= syncMeta_r;
      end
   end

   logic attnS;
   logic pendS;
   logic flagS;
   logic halfS;
   logic nearS;
   logic inRdyS;
   logic outRdyS;

   assign {outRdyS, inRdyS, nearS, halfS, flagS, pendS, attnS} = sync_r;

   // ------------------------------------------------------------------
   // Software registers
   // ------------------------------------------------------------------
   logic [7:0]  ctrl_r;
   logic [7:0]  cfg_r;
   logic [7:0]  cnt0_r;
   logic [7:0]  cnt1_r;
   logic [7:0]  cnt2_r;
   logic        attnFlag_r;
   logic        pendFlag_r;
   logic        zeroFlag_r;
   logic        irq_r;
   logic        flagOut_r;
   logic [2:0]  statusClr;
   logic        burstOk;
   logic        hsBusy;

   function automatic logic hit(input logic stb, input logic [3:0] a, input logic [3:0] ofs);
      hit = stb && (a == ofs);
   endfunction

   assign statusClr = hit(regWrStb, regAddr, OFS_STATUS) ? regWrData[2:0] : 3'h0;

   // Mode bits are used unsynchronised; software idles the handshake first
   always_ff @(posedge ref_clk or negedge rstSync_r)
   begin
      if (!rstSync_r)
      begin
         ctrl_r <= CTRL_RST;
         cfg_r  <= CFG_RST;
      end
      else
      begin
         if (hit(regWrStb, regAddr, OFS_CTRL))
         begin
            ctrl_r <= regWrData;
         end
         if (hit(regWrStb, regAddr, OFS_CFG))
         begin
            cfg_r <= regWrData;
         end
      end
   end

   logic       fpEnable;
   logic       outMode;
   logic [1:0] stretchSel;
   logic [1:0] filterSel;

   assign fpEnable   = ctrl_r[CTRL_FPEN];
   assign outMode    = ctrl_r[CTRL_OUTM];
   assign stretchSel = cfg_r[CFG_STR_LO +: 2];
   assign filterSel  = cfg_r[CFG_FLT_LO +: 2];

   assign peripheralDirectionOption = ctrl_r[CTRL_DIRHS];
   assign handshakeEndOption        = ctrl_r[CTRL_DIRHS];

   always_ff @(posedge ref_clk or negedge rstSync_r)
   begin
      if (!rstSync_r)
      begin
         regRdData <= 8'h00;
      end
      else if (regRdStb)
      begin
         case (regAddr)
            OFS_CTRL:   regRdData <= ctrl_r;
            OFS_CFG:    regRdData <= cfg_r;
            OFS_CNT0:   regRdData <= cnt0_r;
            OFS_CNT1:   regRdData <= cnt1_r;
            OFS_CNT2:   regRdData <= cnt2_r;
            OFS_STATUS: regRdData <= {hsBusy, burstOk, flagOut_r, attnS,
                                      irq_r, zeroFlag_r, pendFlag_r, attnFlag_r};
            default:    regRdData <= 8'h00;
         endcase
      end
      else
      begin
         regRdData <= 8'h00;
      end
   end

   // ------------------------------------------------------------------
   // Step tick for stretcher and filter
   // ------------------------------------------------------------------
   // Each stage advances on this tick so a stage stands for 50 ns
   logic [1:0] stepCnt_r;
   logic       stepTick;

   assign stepTick = (stepCnt_r == STEP_LAST);

   always_ff @(posedge ref_clk or negedge rstSync_r)
   begin
      if (!rstSync_r)
      begin
         stepCnt_r <= 2'h0;
      end
      else
      begin
         stepCnt_r <= stepTick ? 2'h0 : stepCnt_r + 2'h1;
      end
   end

   // ------------------------------------------------------------------
   // Peripheral flag filter
   // ------------------------------------------------------------------
   logic [2:0] fltStage_r;
   logic       fltDone;

   always_comb
   begin
      case (filterSel)
         2'h1:    fltDone = fltStage_r[0];
         2'h2:    fltDone = fltStage_r[1];
         default: fltDone = fltStage_r[2];
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstSync_r)
   begin
      if (!rstSync_r)
      begin
         fltStage_r <= 3'h0;
         flagOut_r  <= 1'b0;
      end
      else if (filterSel == 2'h0)
      begin
         fltStage_r <= 3'h0;
         flagOut_r  <= flagS;
      end
      else if (flagS == flagOut_r)
      begin
         fltStage_r <= 3'h0;
      end
      else if (stepTick)
      begin
         fltStage_r <= {fltStage_r[1:0], 1'b1};
         if (fltDone)
         begin
            flagOut_r <= flagS;
         end
      end
   end

   // ------------------------------------------------------------------
   // Interrupt sources and request
   // ------------------------------------------------------------------
   logic counterCarry;
   logic attnSrc;
   logic pendSrc;
   logic zeroSrc;
   logic anySrc;
   logic irqArm_r;

   always_ff @(posedge ref_clk or negedge rstSync_r)
   begin
      if (!rstSync_r)
      begin
         attnFlag_r <= 1'b0;
         pendFlag_r <= 1'b0;
         zeroFlag_r <= 1'b0;
      end
      else
      begin
         // Set wins over a software clear in the same cycle
         attnFlag_r <= attnS | (attnFlag_r & ~statusClr[ST_ATTN]);
         pendFlag_r <= pendS | (pendFlag_r & ~statusClr[ST_PERIPHERAL_END_INPUT]);
         zeroFlag_r <= counterCarry | (zeroFlag_r & ~statusClr[ST_ZERO]);
      end
   end

   assign attnSrc = attnS & ctrl_r[CTRL_ATTNE];
   assign pendSrc = pendFlag_r & ctrl_r[CTRL_PENDE];
   assign zeroSrc = zeroFlag_r & ctrl_r[CTRL_ZEROE];
   assign anySrc  = attnSrc | pendSrc | zeroSrc;

   always_ff @(posedge ref_clk or negedge rstSync_r)
   begin
      if (!rstSync_r)
      begin
         irq_r    <= 1'b0;
         irqArm_r <= 1'b1;
      end
      else
      begin
         irq_r    <= anySrc & (irq_r | irqArm_r);
         irqArm_r <= ~anySrc;
      end
   end

   assign irq = irq_r;

   // ------------------------------------------------------------------
   // Handshake state machines
   // ------------------------------------------------------------------
   // Output mode uses hsIn_r, which drives fifoShiftOut; input mode uses hsOut_r, which drives fifoShiftIn
   fhc_hs_state_e hsIn_r;
   fhc_hs_state_e hsOut_r;
   logic          hsEnable;
   logic          goIn;
   logic          goOut;
   logic          xferIn;
   logic          xferOut;

   function automatic fhc_hs_state_e hsNext(input fhc_hs_state_e s, input logic go,
                                            input logic flag);
      case (s)
         HS_IDLE:    hsNext = go ? HS_STROBE : HS_IDLE;
         HS_STROBE:  hsNext = flag ? HS_RELEASE : HS_STROBE;
         HS_RELEASE: hsNext = flag ? HS_RELEASE : HS_IDLE;
         default:    hsNext = HS_IDLE;
      endcase
   endfunction

   assign hsEnable = fpEnable & ~zeroFlag_r & ~pendFlag_r;
   assign goIn     = hsEnable & outMode & outRdyS;
   assign goOut    = hsEnable & ~outMode & inRdyS;
   assign xferIn   = (hsIn_r == HS_STROBE) & flagOut_r;
   assign xferOut  = (hsOut_r == HS_STROBE) & flagOut_r;
   assign hsBusy   = (hsIn_r != HS_IDLE) | (hsOut_r != HS_IDLE);

   always_ff @(posedge ref_clk or negedge rstSync_r)
   begin
      if (!rstSync_r)
      begin
         hsIn_r <= HS_IDLE;
      end
      else if (!ctrlClr_n)
      begin
         hsIn_r <= HS_IDLE;
      end
      else
      begin
         hsIn_r <= hsNext(hsIn_r, goIn, flagOut_r);
      end
   end

   always_ff @(posedge ref_clk or negedge rstSync_r)
   begin
      if (!rstSync_r)
      begin
         hsOut_r <= HS_IDLE;
      end
      else if (!ctrlClr_n)
      begin
         hsOut_r <= HS_IDLE;
      end
      else
      begin
         hsOut_r <= hsNext(hsOut_r, goOut, flagOut_r);
      end
   end

   // FIFO shift pulses registered, forced low while clear is held
   logic shiftOut_r;
   logic shiftIn_r;

   always_ff @(posedge ref_clk or negedge rstSync_r)
   begin
      if (!rstSync_r)
      begin
         shiftOut_r <= 1'b0;
         shiftIn_r  <= 1'b0;
      end
      else
      begin
         shiftOut_r <= xferIn & ctrlClr_n;
         shiftIn_r  <= xferOut & ctrlClr_n;
      end
   end

   assign fifoShiftOut = shiftOut_r & ctrlClr_n;
   assign fifoShiftIn  = shiftIn_r & ctrlClr_n;

   // Clear forces both terms high at once, not at the next edge
   assign outboundStrobeTerm_n = ~((hsIn_r == HS_STROBE) & ctrlClr_n);
   assign inboundStrobeTerm_n  = ~((hsOut_r == HS_STROBE) & ctrlClr_n);

   // ------------------------------------------------------------------
   // Strobe stretcher
   // ------------------------------------------------------------------
   // Asserted when either active-low term is asserted; they never overlap
   logic       strobeInt_n;
   logic [2:0] stretch_r;

   assign strobeInt_n = outboundStrobeTerm_n & inboundStrobeTerm_n;

   always_ff @(posedge ref_clk or negedge rstSync_r)
   begin
      if (!rstSync_r)
      begin
         stretch_r <= 3'h7;
      end
      else if (!ctrlClr_n)
      begin
         stretch_r <= 3'h7;
      end
      else if (stepTick)
      begin
         if (strobeInt_n)
         begin
            stretch_r <= 3'h7;
         end
         else
         begin
            stretch_r <= {stretch_r[1:0], strobeInt_n};
         end
      end
   end

   always_comb
   begin
      case (stretchSel)
         2'h0:    peripheralStrobe_n = strobeInt_n;
         2'h1:    peripheralStrobe_n = stretch_r[0] | ~ctrlClr_n;
         2'h2:    peripheralStrobe_n = stretch_r[1] | ~ctrlClr_n;
         default: peripheralStrobe_n = stretch_r[2] | ~ctrlClr_n;
      endcase
   end

   // ------------------------------------------------------------------
   // Burst and single transfer requests
   // ------------------------------------------------------------------
   // Nine words of room (output) or of data (input) keep burst on,
   // leaving an eight-word cushion for the channel to stop in
   logic nineAvail;

   assign nineAvail     = ~nearS | (outMode ? ~halfS : halfS);
   assign burstOk       = nineAvail & ~pendFlag_r;
   assign burstRequest  = burstOk & ctrlClr_n;
   assign singleRequest = ~burstOk & ~outMode & ~pendFlag_r & outRdyS
                          & ctrlClr_n;

   // ------------------------------------------------------------------
   // Transfer counter
   // ------------------------------------------------------------------
   logic xfer;
   logic carry0;
   logic carry1;

   assign xfer         = xferIn | xferOut;
   assign carry0       = xfer & (cnt0_r == CNT_MAX);
   assign carry1       = carry0 & (cnt1_r == CNT_MAX);
   assign counterCarry = carry1 & (cnt2_r == CNT_MAX);
   assign termCount    = zeroFlag_r;

   always_ff @(posedge ref_clk or negedge rstSync_r)
   begin
      if (!rstSync_r)
      begin
         cnt0_r <= CNT_RST;
         cnt1_r <= CNT_RST;
         cnt2_r <= CNT_RST;
      end
      else
      begin
         if (hit(regWrStb, regAddr, OFS_CNT0))
            cnt0_r <= regWrData;
         else if (xfer)
            cnt0_r <= cnt0_r + 8'h01;
         if (hit(regWrStb, regAddr, OFS_CNT1))
            cnt1_r <= regWrData;
         else if (carry0)
            cnt1_r <= cnt1_r + 8'h01;
         if (hit(regWrStb, regAddr, OFS_CNT2))
            cnt2_r <= regWrData;
         else if (carry1)
            cnt2_r <= cnt2_r + 8'h01;
      end
   end

   // ------------------------------------------------------------------
   // Frontplane data driver enable
   // ------------------------------------------------------------------
   // Drivers on only in output mode with the frontplane enabled
   assign dataDrvEn_n = ~(fpEnable & outMode & ctrlClr_n);

endmodule // fhc_frontplane_ctl

`default_nettype wire

// ==== fhc_pkg.sv ====
/*
   Package for the frontplane handshake control block: register map, field
   positions, reset values, step timing and handshake state codes.
   Assumes a single 40 MHz clock and an 8-bit software register port.
*/
`default_nettype none

package fhc_pkg;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam int           ADDR_W      = 4;
   localparam int           DATA_W      = 8;
   localparam logic [3:0]   OFS_CTRL    = 4'h0;
   localparam logic [3:0]   OFS_STATUS  = 4'h1;
   localparam logic [3:0]   OFS_CNT0    = 4'h2;
   localparam logic [3:0]   OFS_CNT1    = 4'h3;
   localparam logic [3:0]   OFS_CNT2    = 4'h4;
   localparam logic [3:0]   OFS_CFG     = 4'h5;

   // Control register fields
   localparam int           CTRL_FPEN   = 0;
   localparam int           CTRL_OUTM   = 1;
   localparam int           CTRL_DIRHS  = 2;
   localparam int           CTRL_ATTNE  = 3;
   localparam int           CTRL_PENDE  = 4;
   localparam int           CTRL_ZEROE  = 5;
   localparam logic [7:0]   CTRL_RST    = 8'h00;

   // Configuration register fields
   localparam int           CFG_STR_LO  = 0;
   localparam int           CFG_FLT_LO  = 2;
   localparam logic [7:0]   CFG_RST     = 8'h00;

   // Status register fields (bits 0..2 are write-one-to-clear)
   localparam int           ST_ATTN     = 0;
   localparam int           ST_PERIPHERAL_END_INPUT     = 1;
   localparam int           ST_ZERO     = 2;
   localparam int           ST_IRQ      = 3;
   localparam int           ST_ATTNLVL  = 4;
   localparam int           ST_FLAG     = 5;
   localparam int           ST_BURST    = 6;
   localparam int           ST_BUSY     = 7;

   localparam logic [7:0]   CNT_RST     = 8'h00;
   localparam logic [7:0]   CNT_MAX     = 8'hFF;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int           CLK_PERIOD_NS = 25;
   localparam int           STEP_NS       = 50;
   localparam int           STEP_CYC      = (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0]   STEP_LAST     = 2'(STEP_CYC - 1);

   // ------------------------------------------------------------------
   // Handshake state machine
   // ------------------------------------------------------------------
   typedef enum logic [2:0]
   {
      HS_IDLE    = 3'b001,
      HS_STROBE  = 3'b010,
      HS_RELEASE = 3'b100
   } fhc_hs_state_e;

endpackage : fhc_pkg

`default_nettype wire

// ==== fhc_ctl_asserts.sv ====
/*
   Port checker for fhc_frontplane_ctl: strobe terms, clear, options.
   Assumes it is bound into every instance of that module.
*/
`timescale 1ns/1ps
`default_nettype none
module fhc_ctl_asserts (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic ctrlClr_n,
   input wire logic outboundStrobeTerm_n,
   input wire logic inboundStrobeTerm_n,
   input wire logic peripheralStrobe_n,
   input wire logic fifoShiftOut,
   input wire logic fifoShiftIn,
   input wire logic burstRequest,
   input wire logic singleRequest,
   input wire logic dataDrvEn_n,
   input wire logic peripheralDirectionOption,
   input wire logic handshakeEndOption
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire logic termsIdle = outboundStrobeTerm_n & inboundStrobeTerm_n;

   a_terms_exclusive: assert property (termsIdle || outboundStrobeTerm_n || inboundStrobeTerm_n)
      else $error("both strobe terms low");
   a_clear_quiet: assert property (!ctrlClr_n |-> termsIdle && !fifoShiftOut && !fifoShiftIn)
      else $error("outputs active in clear");
   a_clear_drivers: assert property (!ctrlClr_n |-> dataDrvEn_n && !burstRequest)
      else $error("drivers or burst on in clear");
   a_options_tied: assert property (peripheralDirectionOption == handshakeEndOption)
      else $error("option bits differ");
   a_burst_single: assert property (!(burstRequest && singleRequest))
      else $error("burst and single together");
   a_trail_release: assert property (termsIdle [*4] |-> peripheralStrobe_n)
      else $error("strobe held after release");
   a_strobe_cause: assert property ($fell(peripheralStrobe_n) |-> !termsIdle)
      else $error("strobe without term");
   a_term_hold: assert property ($fell(termsIdle) |-> !termsIdle [*3])
      else $error("term released too soon");
endmodule // fhc_ctl_asserts

bind fhc_frontplane_ctl fhc_ctl_asserts chk (.*);
`default_nettype wire

// ==== fhc_periph_model.sv ====
/*
   Peripheral model: answers the frontplane strobe with its flag.
   Assumes lag stays steady while a strobe is pending.
*/
`timescale 1ns/1ps
`default_nettype none
module fhc_periph_model (
   input  wire logic       ref_clk,
   input  wire logic [3:0] lag,
   input  wire logic       peripheralStrobe_n,
   output logic            peripheralFlagInput
);
   logic [3:0] waitCnt;
   initial
   begin
      peripheralFlagInput = 1'b0;
      waitCnt = 4'h0;
   end
   // Flag mirrors the strobe lag cycles late, so prompt and slow peers occur
   always @(posedge ref_clk)
   begin
      if (peripheralFlagInput != peripheralStrobe_n)
         waitCnt <= 4'h0;
      else if (waitCnt >= lag)
         peripheralFlagInput <= ~peripheralStrobe_n;
      else
         waitCnt <= waitCnt + 4'h1;
   end
endmodule // fhc_periph_model
`default_nettype wire

// ==== fhc_frontplane_ctl_test.sv ====
/*
   Self-checking bench of fhc_frontplane_ctl with a peripheral model.
   Assumes the register map of fhc_pkg.
*/
`timescale 1ns/1ps
`default_nettype none
module fhc_frontplane_ctl_test;
   import fhc_pkg::*;
   logic ref_clk, rst_n, ctrlClr_n, regWrStb, regRdStb, attentionInput;
   logic peripheralEndInput, peripheralFlagInput, fifoHalfFull, fifoNearLimit;
   logic fifoInputReady, fifoOutputReady, irq, dataDrvEn_n, outboundStrobeTerm_n;
   logic inboundStrobeTerm_n, peripheralStrobe_n, fifoShiftOut, fifoShiftIn;
   logic burstRequest, singleRequest, peripheralDirectionOption, handshakeEndOption;
   logic termCount;
   logic       sawOut = 1'b0;
   logic       sawIn = 1'b0;
   logic [3:0] regAddr, lag;
   logic [7:0] regWrData, regRdData, rdv;
   int         error_cnt, n_checks, cycles, nShift, d, tl;

   fhc_frontplane_ctl dut (.*);
   fhc_periph_model peer (.*);

   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk)
   begin
      cycles <= cycles + 1;
      nShift <= nShift + int'(fifoShiftOut) + int'(fifoShiftIn);
      if (!outboundStrobeTerm_n) sawOut <= 1'b1;
      if (!inboundStrobeTerm_n) sawIn <= 1'b1;
      if (cycles == 20000)
      begin
         error_cnt++;
         finish_test();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wreg(input logic [3:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      {regAddr, regWrData, regWrStb} <= {a, v, 1'b1};
      @(posedge ref_clk);
      regWrStb <= 1'b0;
   endtask

   task automatic rreg(input logic [3:0] a, output logic [7:0] v);
      @(posedge ref_clk);
      {regAddr, regRdStb} <= {a, 1'b1};
      @(posedge ref_clk);
      regRdStb <= 1'b0;
      @(negedge ref_clk);
      v = regRdData;
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic t_reset();
      logic [3:0] al[6];
      al = '{OFS_CTRL, OFS_CNT0, OFS_CNT1, OFS_CNT2, OFS_CFG, 4'hF};
      foreach (al[i]) wreg(al[i], 8'h5E);
      @(negedge ref_clk);
      chk(8'({peripheralDirectionOption, handshakeEndOption}), 8'h03);
      rst_n <= 1'b0;
      @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      foreach (al[i])
      begin
         rreg(al[i], rdv);
         chk(rdv, 8'h00);
      end
      $display("reset done");
   endtask

   task automatic t_burst();
      logic b;
      for (int m = 0; m < 2; m++)
      begin
         wreg(OFS_CTRL, 8'(m << 1));
         for (int k = 0; k < 4; k++)
         begin
            @(posedge ref_clk);
            {fifoNearLimit, fifoHalfFull, fifoOutputReady} <= {2'(k), 1'b1};
            repeat (4) @(negedge ref_clk);
            b = !fifoNearLimit || (m == 1 ? !fifoHalfFull : fifoHalfFull);
            chk(8'({burstRequest, singleRequest}), 8'({b, m == 0 && !b}));
         end
      end
      $display("burst done");
   endtask

   task automatic t_count();
      int s0;
      for (int a = 0; a < 3; a++) wreg(4'(OFS_CNT0 + a), 8'hFF);
      s0 = nShift;
      {fifoNearLimit, fifoHalfFull, fifoInputReady} <= 3'b001;
      wreg(OFS_CTRL, 8'h03);
      for (int n = 0; n < 300 && termCount !== 1'b1; n++) @(negedge ref_clk);
      repeat (40) @(negedge ref_clk);
      chk(8'(nShift - s0), 8'h01);
      chk(8'({termCount, irq, sawOut, sawIn}), 8'h0A);
      chk(8'(dataDrvEn_n), 8'h00);
      for (int a = 0; a < 3; a++)
      begin
         rreg(4'(OFS_CNT0 + a), rdv);
         chk(rdv, 8'h00);
      end
      wreg(OFS_CTRL, 8'h23);
      repeat (2) @(negedge ref_clk);
      chk(8'(irq), 8'h01);
      wreg(OFS_CTRL, 8'h22);
      wreg(OFS_STATUS, 8'h04);
      repeat (2) @(negedge ref_clk);
      chk(8'({irq, termCount}), 8'h00);
      $display("count done");
   endtask

   task automatic t_attn();
      wreg(OFS_CTRL, 8'h08);
      attentionInput <= 1'b1;
      repeat (3) @(negedge ref_clk);
      chk(8'(irq), 8'h00);
      repeat (2) @(negedge ref_clk);
      chk(8'(irq), 8'h01);
      rreg(OFS_STATUS, rdv);
      chk(8'(rdv[ST_ATTN]), 8'h01);
      @(posedge ref_clk);
      attentionInput <= 1'b0;
      repeat (5) @(negedge ref_clk);
      chk(8'(irq), 8'h00);
      wreg(OFS_STATUS, 8'h01);
      attentionInput <= 1'b1;
      repeat (5) @(negedge ref_clk);
      chk(8'(irq), 8'h01);
      @(posedge ref_clk);
      attentionInput <= 1'b0;
      // Masked end flag must not interrupt but must still stop burst and single
      wreg(OFS_CTRL, 8'h00);
      peripheralEndInput <= 1'b1;
      repeat (6) @(negedge ref_clk);
      chk(8'({irq, burstRequest, singleRequest}), 8'h00);
      wreg(OFS_CTRL, 8'h10);
      repeat (2) @(negedge ref_clk);
      chk(8'(irq), 8'h01);
      @(posedge ref_clk);
      peripheralEndInput <= 1'b0;
      repeat (3) @(negedge ref_clk);
      wreg(OFS_STATUS, 8'h02);
      repeat (2) @(negedge ref_clk);
      chk(8'(irq), 8'h00);
      $display("attention done");
   endtask

   // Each pass pairs a stretch step with the same filter step and a longer lag
   task automatic t_stretch();
      for (int s = 0; s < 4; s++)
      begin
         wreg(OFS_CTRL, 8'h00);
         wreg(OFS_CFG, 8'(s * 5));
         lag <= 4'(3 * s);
         wreg(OFS_CTRL, 8'h01);
         for (int n = 0; n < 50 && inboundStrobeTerm_n; n++) @(negedge ref_clk);
         for (d = 0; d < 20 && peripheralStrobe_n; d++) @(negedge ref_clk);
         for (tl = d; tl < 90 && !inboundStrobeTerm_n; tl++) @(negedge ref_clk);
         chk(8'(s == 0 ? d == 0 : d >= 2 * s - 2 && d <= 2 * s + 1), 8'h01);
         chk(8'(tl >= d + 5 * s), 8'h01);
      end
      wreg(OFS_CFG, 8'h00);
      lag <= 4'h1;
      for (int n = 0; n < 50 && inboundStrobeTerm_n; n++) @(negedge ref_clk);
      // Let the term stand its minimum time before clear cuts it short
      repeat (2) @(posedge ref_clk);
      @(posedge ref_clk);
      ctrlClr_n <= 1'b0;
      @(negedge ref_clk);
      chk(8'({inboundStrobeTerm_n, peripheralStrobe_n, dataDrvEn_n, fifoShiftIn}), 8'h0E);
      @(posedge ref_clk);
      ctrlClr_n <= 1'b1;
      wreg(OFS_CTRL, 8'h00);
      $display("stretch done");
   endtask

   initial
   begin
      {ctrlClr_n, lag, rst_n, regWrStb, regRdStb} = {1'b1, 4'h1, 3'b000};
      {attentionInput, peripheralEndInput, regAddr, regWrData} = '0;
      {fifoHalfFull, fifoNearLimit, fifoInputReady, fifoOutputReady} = '0;
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      t_reset();
      t_burst();
      t_count();
      t_attn();
      t_stretch();
      finish_test();
   end
endmodule // fhc_frontplane_ctl_test
`default_nettype wire
